// ===== dv/pief_event_src.sv
// peripheral event sources: event outputs follow req, registered one cycle later
`timescale 1ns/1ps
module pief_event_src (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] req,
  output pief_pkg::pief_events_t ev
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev <= '0;
    end else begin
      ev <= req;
    end
  end
endmodule // pief_event_src

// ===== dv/pief_irq_regs_monitor.sv
// assertion checker for the peripheral interrupt register block
`timescale 1ns/1ps
module pief_irq_regs_monitor (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [pief_pkg::ADR_W-1:0] WB_ADR_I,
  input wire logic [pief_pkg::DAT_W-1:0] WB_DAT_I,
  input wire logic [pief_pkg::DAT_W-1:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic EV_CONV_DONE,
  input wire logic EV_SERIAL_PORT,
  input wire logic EV_CAPTURE_COMPARE,
  input wire logic EV_TIMER_MATCH,
  input wire logic EV_TIMER_OVERFLOW,
  input wire logic CORE_IRQ,
  input wire logic IRQ
);
  logic [7:0] ctl_s;
  logic [7:0] en_s;
  wire logic [7:0] ix = WB_ADR_I[9:2];
  wire logic wr = WB_CYC_I && WB_STB_I && !WB_ACK_O && CE && WB_WE_I && WB_SEL_I[0];
  wire logic rd = WB_ACK_O && !WB_WE_I;
  // shadow of control and enables
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctl_s <= 8'h00;
      en_s <= 8'h00;
    end else if (wr && (ix == 8'h0b || ix == 8'h8b)) begin
      ctl_s <= WB_DAT_I[7:0];
    end else if (wr && ix == 8'h8c) begin
      en_s <= WB_DAT_I[7:0] & 8'h4f;
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  property p_src(ev, int b);
    ev && CE && ctl_s[7:6] == 2'b11 && en_s[b] && !wr ##1 CE |=> CORE_IRQ;
  endproperty
  AST_CTL_MIRROR: assert property (
    rd && (ix == 8'h0b || ix == 8'h8b) |-> WB_DAT_O[7:0] == ctl_s)
    else $error("control read differs");
  AST_ENA_READ: assert property (rd && ix == 8'h8c |-> WB_DAT_O[7:0] == en_s)
    else $error("enable read differs");
  AST_FLAG_RSVD: assert property (
    rd && ix == 8'h0c |-> (WB_DAT_O[7:0] & 8'hb0) == 8'h00)
    else $error("flag spare bits set");
  AST_GROUP_GATE: assert property (CORE_IRQ && $past(CE) |-> $past(ctl_s[6]))
    else $error("irq without group enable");
  AST_GLOBAL_GATE: assert property (CORE_IRQ && $past(CE) |-> $past(ctl_s[7]))
    else $error("irq without global enable");
  AST_CONV_EN: assert property (p_src(EV_CONV_DONE, 6))
    else $error("conversion irq missing");
  AST_CAPCMP_EN: assert property (p_src(EV_CAPTURE_COMPARE, 2))
    else $error("capture irq missing");
  AST_MATCH_EN: assert property (p_src(EV_TIMER_MATCH, 1))
    else $error("match irq missing");
  cover property ($rose(CORE_IRQ));
  cover property ($rose(IRQ));
  cover property (rd && ix == 8'h8b);
endmodule // pief_irq_regs_monitor
bind pief_irq_regs pief_irq_regs_monitor pief_irq_regs_monitor_i (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .CE(CE), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_SEL_I(WB_SEL_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .EV_CONV_DONE(EV_CONV_DONE),
  .EV_SERIAL_PORT(EV_SERIAL_PORT), .EV_CAPTURE_COMPARE(EV_CAPTURE_COMPARE),
  .EV_TIMER_MATCH(EV_TIMER_MATCH), .EV_TIMER_OVERFLOW(EV_TIMER_OVERFLOW),
  .CORE_IRQ(CORE_IRQ), .IRQ(IRQ));

// ===== dv/pief_irq_regs_tb.sv
// self-checking bench for the peripheral interrupt register block
`timescale 1ns/1ps
module pief_irq_regs_tb;
  logic clk, rstn, ce, cyc, stb, we, ack, core_irq, irq;
  logic [9:0] adr;
  logic [31:0] dat, dato;
  logic [4:0] req;
  logic [7:0] r;
  pief_pkg::pief_events_t ev;
  int n_fail, checks;
  int srcs [5] = '{6, 3, 2, 1, 0};
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  pief_event_src pief_event_src_i (.clk(clk), .rst_n(rstn), .req(req), .ev(ev));
  pief_irq_regs pief_irq_regs_i (.CORE_CLK(clk), .RSTN(rstn), .CE(ce), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_SEL_I(4'h1), .WB_ADR_I(adr), .WB_DAT_I(dat),
    .WB_DAT_O(dato), .WB_ACK_O(ack), .EV_CONV_DONE(ev.conv_done),
    .EV_SERIAL_PORT(ev.serial_port), .EV_CAPTURE_COMPARE(ev.capture_compare),
    .EV_TIMER_MATCH(ev.timer_match), .EV_TIMER_OVERFLOW(ev.timer_overflow),
    .CORE_IRQ(core_irq), .IRQ(irq));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic [7:0] ix, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    dat <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) n_fail++;
    r = dato[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] ix, input logic [7:0] exp);
    wb(ix, 1'b0, 8'h00);
    chk(nm, r, exp);
  endtask
  task automatic fire(input int b);
    @(posedge clk);
    req <= 5'(1 << (b == 6 ? 4 : b));
    @(posedge clk);
    req <= 5'h00;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_mirror();
    rchk("ctl", 8'h0b, 8'h00);
    rchk("flags", 8'h0c, 8'h00);
    rchk("enables", 8'h8c, 8'h00);
    wb(8'h0b, 1'b1, 8'h3c);
    rchk("ctl alt", 8'h8b, 8'h3c);
    wb(8'h8b, 1'b1, 8'h05);
    rchk("ctl", 8'h0b, 8'h05);
    wb(8'h8c, 1'b1, 8'hff);
    rchk("enables", 8'h8c, 8'h4f);
    rchk("unmapped", 8'h55, 8'h00);
    wb(8'h8c, 1'b1, 8'h00);
  endtask
  task automatic t_gate();
    wb(8'h0b, 1'b1, 8'hc0);
    for (int i = 0; i < 5; i++) fire(srcs[i]);
    chk("no enables", {7'h0, core_irq}, 8'h00);
    rchk("flags", 8'h0c, 8'h4f);
    for (int i = 0; i < 5; i++) begin
      wb(8'h0b, 1'b1, 8'hc0);
      wb(8'h0c, 1'b1, 8'h00);
      wb(8'h8c, 1'b1, 8'h01 << srcs[i]);
      fire(srcs[(i + 1) % 5]);
      chk("other src", {7'h0, core_irq}, 8'h00);
      fire(srcs[i]);
      chk("own src", {7'h0, core_irq}, 8'h01);
      wb(8'h0b, 1'b1, 8'h80);
      @(posedge clk);
      chk("no group", {7'h0, core_irq}, 8'h00);
      wb(8'h0b, 1'b1, 8'h40);
      @(posedge clk);
      chk("no global", {7'h0, core_irq}, 8'h00);
    end
  endtask
  task automatic t_status();
    wb(8'h90, 1'b1, 8'hff);
    wb(8'h91, 1'b1, 8'h01);
    fire(0);
    chk("irq", {7'h0, irq}, 8'h01);
    rchk("status", 8'h90, 8'h01);
    wb(8'h91, 1'b1, 8'h00);
    @(posedge clk);
    chk("irq masked", {7'h0, irq}, 8'h00);
    wb(8'h91, 1'b1, 8'h01);
    wb(8'h90, 1'b1, 8'h01);
    @(posedge clk);
    chk("irq cleared", {7'h0, irq}, 8'h00);
    ce <= 1'b0;
    fire(0);
    ce <= 1'b1;
    @(posedge clk);
    chk("frozen irq", {7'h0, irq}, 8'h00);
    rchk("frozen status", 8'h90, 8'h00);
  endtask
  task automatic final_report();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    {rstn, cyc, stb, we, adr, dat, req} = '0;
    ce = 1'b1;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_mirror();
    t_gate();
    t_status();
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    final_report();
  end
endmodule // pief_irq_regs_tb

// ===== verilog/pief_flag_bank.sv
// bank of hardware-set flags with software write, set wins over write
`timescale 1ns/1ps
module pief_flag_bank #(
  parameter int W = 8,
  parameter logic [7:0] IMPL = 8'hff,
  parameter bit W1C = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] set,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  output logic [W-1:0] q
);

  // ==========================================================
  // per-bit flag
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic bit_d;
      logic bit_q;
      always_comb begin
        bit_d = bit_q;
        if (!IMPL[i]) begin
          bit_d = 1'b0;
        end else if (set[i]) begin
          bit_d = 1'b1;
        end else if (wr_en) begin
          bit_d = W1C ? (bit_q & ~wr_data[i]) : wr_data[i];
        end
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          bit_q <= 1'b0;
        end else if (ce) begin
          bit_q <= bit_d;
        end
      end
      assign q[i] = bit_q;
    end
  endgenerate

endmodule // pief_flag_bank

// ===== verilog/pief_irq_regs.sv
// peripheral interrupt enable, flag and control registers on a wishbone slave
`timescale 1ns/1ps
module pief_irq_regs #(
  parameter bit HAS_CONVERTER = 1'b1
) (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [pief_pkg::ADR_W-1:0] WB_ADR_I,
  input wire logic [pief_pkg::DAT_W-1:0] WB_DAT_I,
  output logic [pief_pkg::DAT_W-1:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic EV_CONV_DONE,
  input wire logic EV_SERIAL_PORT,
  input wire logic EV_CAPTURE_COMPARE,
  input wire logic EV_TIMER_MATCH,
  input wire logic EV_TIMER_OVERFLOW,
  output logic CORE_IRQ,
  output logic IRQ
);

  // ==========================================================
  // request and decode
  pief_pkg::pief_wb_req_t req;
  pief_pkg::pief_events_t ev;
  logic [7:0] idx;
  logic access;
  logic wr;
  logic hit_ctl;
  logic hit_flags;
  logic hit_en;
  logic hit_stat;
  logic hit_mask;

  assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, sel: WB_SEL_I,
                 adr: WB_ADR_I, dat: WB_DAT_I};
  assign ev = '{conv_done: EV_CONV_DONE, serial_port: EV_SERIAL_PORT,
                capture_compare: EV_CAPTURE_COMPARE, timer_match: EV_TIMER_MATCH,
                timer_overflow: EV_TIMER_OVERFLOW};

  logic ack_q;
  logic ack_d;
  assign idx = req.adr[pief_pkg::ADR_W-1:2];
  assign access = req.cyc & req.stb & ~ack_q;
  assign wr = access & req.we & req.sel[0];
  assign hit_ctl = (idx == pief_pkg::IDX_IRQ_CONTROL) |
                   (idx == pief_pkg::IDX_IRQ_CONTROL_ALT);
  assign hit_flags = (idx == pief_pkg::IDX_PERIPH_FLAGS);
  assign hit_en = (idx == pief_pkg::IDX_PERIPH_ENABLES);
  assign hit_stat = (idx == pief_pkg::IDX_EVENT_STATUS);
  assign hit_mask = (idx == pief_pkg::IDX_EVENT_MASK);

  // ==========================================================
  // implemented bit mask, conversion bit dropped without converter
  localparam logic [7:0] IMPL = HAS_CONVERTER ? pief_pkg::PERIPH_IMPL_MASK :
                                (pief_pkg::PERIPH_IMPL_MASK & 8'hbf);

  // ==========================================================
  // event vector in flag layout
  logic [7:0] ev_vec;
  always_comb begin
    ev_vec = 8'h00;
    ev_vec[pief_pkg::BIT_CONV_DONE] = ev.conv_done;
    ev_vec[pief_pkg::BIT_SERIAL] = ev.serial_port;
    ev_vec[pief_pkg::BIT_CAPCMP] = ev.capture_compare;
    ev_vec[pief_pkg::BIT_TMR_MATCH] = ev.timer_match;
    ev_vec[pief_pkg::BIT_TMR_OVF] = ev.timer_overflow;
  end

  // ==========================================================
  // control and enable registers
  logic [7:0] ctl_q;
  logic [7:0] ctl_d;
  logic [7:0] en_q;
  logic [7:0] en_d;
  logic [7:0] mask_q;
  logic [7:0] mask_d;

  always_comb begin
    ctl_d = ctl_q;
    en_d = en_q;
    mask_d = mask_q;
    if (wr && hit_ctl) begin
      ctl_d = req.dat[7:0];
    end
    if (wr && hit_en) begin
      en_d = req.dat[7:0] & IMPL;
    end
    if (wr && hit_mask) begin
      mask_d = req.dat[7:0] & IMPL;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctl_q <= pief_pkg::RST_IRQ_CONTROL;
      en_q <= pief_pkg::RST_PERIPH;
      mask_q <= pief_pkg::RST_PERIPH;
    end else if (CE) begin
      ctl_q <= ctl_d;
      en_q <= en_d;
      mask_q <= mask_d;
    end
  end

  // ==========================================================
  // peripheral flags and sticky event status
  logic [7:0] flags_q;
  logic [7:0] stat_q;

  pief_flag_bank #(
    .W(8),
    .IMPL(IMPL),
    .W1C(1'b0)
  ) u_flags (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .ce(CE),
    .set(ev_vec),
    .wr_en(wr & hit_flags),
    .wr_data(req.dat[7:0]),
    .q(flags_q)
  );

  pief_flag_bank #(
    .W(8),
    .IMPL(IMPL),
    .W1C(1'b1)
  ) u_status (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .ce(CE),
    .set(ev_vec),
    .wr_en(wr & hit_stat),
    .wr_data(req.dat[7:0]),
    .q(stat_q)
  );

  // ==========================================================
  // read data and acknowledge
  logic [pief_pkg::DAT_W-1:0] rdat_q;
  logic [pief_pkg::DAT_W-1:0] rdat_d;

  always_comb begin
    ack_d = access;
    rdat_d = rdat_q;
    if (access) begin
      rdat_d = '0;
      if (hit_ctl) begin
        rdat_d[7:0] = ctl_q;
      end else if (hit_flags) begin
        rdat_d[7:0] = flags_q;
      end else if (hit_en) begin
        rdat_d[7:0] = en_q & IMPL;
      end else if (hit_stat) begin
        rdat_d[7:0] = stat_q;
      end else if (hit_mask) begin
        rdat_d[7:0] = mask_q;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else if (CE) begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;

  // ==========================================================
  // interrupt outputs
  logic core_irq_q;
  logic core_irq_d;
  logic irq_q;
  logic irq_d;

  always_comb begin
    // per-source gating by enable bits 6, 3, 2, 1, 0
    core_irq_d = ctl_q[pief_pkg::BIT_GLOBAL_EN] &
                 ctl_q[pief_pkg::BIT_GROUP_EN] &
                 (|(flags_q & en_q & IMPL));
    irq_d = |(stat_q & mask_q);
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      core_irq_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (CE) begin
      core_irq_q <= core_irq_d;
      irq_q <= irq_d;
    end
  end

  assign CORE_IRQ = core_irq_q;
  assign IRQ = irq_q;

endmodule // pief_irq_regs

// ===== verilog/pief_pkg.sv
// shared constants and types of the peripheral interrupt enable and flag block
package pief_pkg;

  // ==========================================================
  // register indices (byte address = index * 4)
  localparam logic [7:0] IDX_IRQ_CONTROL = 8'h0b;
  localparam logic [7:0] IDX_IRQ_CONTROL_ALT = 8'h8b;
  localparam logic [7:0] IDX_PERIPH_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_PERIPH_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_EVENT_STATUS = 8'h90;
  localparam logic [7:0] IDX_EVENT_MASK = 8'h91;

  // ==========================================================
  // field positions
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_GROUP_EN = 6;
  localparam int BIT_CONV_DONE = 6;
  localparam int BIT_SERIAL = 3;
  localparam int BIT_CAPCMP = 2;
  localparam int BIT_TMR_MATCH = 1;
  localparam int BIT_TMR_OVF = 0;

  // implemented bits of flags, enables, status and mask
  localparam logic [7:0] PERIPH_IMPL_MASK = 8'h4f;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] RST_PERIPH = 8'h00;

  // ==========================================================
  // bus width and address
  localparam int ADR_W = 10;
  localparam int DAT_W = 32;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ADR_W-1:0] adr;
    logic [DAT_W-1:0] dat;
  } pief_wb_req_t;

  typedef struct packed {
    logic conv_done;
    logic serial_port;
    logic capture_compare;
    logic timer_match;
    logic timer_overflow;
  } pief_events_t;

endpackage
